// *** shared/dv_cmd_pkg.sv ***
// Shared constants and types for the decade value command parser.
// Assumes a 50 MHz system clock and byte-wide character sources.
package dv_cmd_pkg;

  localparam int unsigned CLK_HZ     = 50000000;
  localparam int unsigned DIGITS     = 10;
  localparam int unsigned KW_LEN     = 12;

  // Bus address limits and power-up latch steps
  localparam logic [4:0] ADDR_RES_LO = 5'h00;
  localparam logic [4:0] ADDR_RES_HI = 5'h1F;
  localparam logic [1:0] BOOT_LATCH  = 2'h2;
  localparam logic [1:0] BOOT_DONE   = 2'h3;

  // Characters
  localparam logic [7:0] CH_LF       = 8'h0A;
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_SP       = 8'h20;
  localparam logic [7:0] CH_PROMPT   = 8'h3E;
  localparam logic [7:0] CH_ECHO_ON  = 8'h05;
  localparam logic [7:0] CH_ECHO_OFF = 8'h06;
  localparam logic [7:0] CH_ZERO     = 8'h30;
  localparam logic [7:0] CH_NINE     = 8'h39;
  localparam logic [7:0] CH_LOW_A    = 8'h61;
  localparam logic [7:0] CH_LOW_Z    = 8'h7A;
  localparam logic [7:0] CASE_BIT    = 8'h20;

  // Keywords, right-justified and zero padded
  localparam logic [95:0] KW_SHORT   = "SOUR:DATA";
  localparam logic [95:0] KW_LONG    = "SOURCE:DATA";
  localparam logic [95:0] KW_RESET   = "*RST";

  // Register offsets
  localparam logic [3:0] REG_FRAME    = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_VALUE_LO = 4'h2;
  localparam logic [3:0] REG_VALUE_HI = 4'h3;

  // Framing encodings
  localparam logic [1:0] PAR_NONE    = 2'h0;
  localparam logic [1:0] PAR_ODD     = 2'h1;
  localparam logic [1:0] PAR_EVEN    = 2'h2;
  localparam logic [3:0] BAUD_9600   = 4'h5;
  localparam logic [3:0] BAUD_MAX    = 4'h9;

  typedef enum logic [1:0] {mode_normal, mode_open, mode_short} out_mode_t;
  typedef enum logic [1:0] {ph_key, ph_val} phase_t;

  typedef struct packed {
    logic [1:0] parity;
    logic       two_stop;
    logic       seven_bits;
    logic [3:0] baud_code;
  } frame_t;

  typedef struct packed {
    frame_t      frame;
    logic [17:0] baud_div;
  } uart_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } char_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic       mode_short;
    logic       mode_open;
    logic       err_exec;
    logic       err_cmd;
    logic [4:0] listen_addr;
    logic       listen_en;
    logic       local_sel;
    logic       echo;
    logic       remote;
  } status_t;

  localparam frame_t FRAME_DEFAULT = '{PAR_NONE, 1'b0, 1'b0, BAUD_9600};

  // Clock cycles per bit for each baud code
  function automatic logic [17:0] baud_div(input logic [3:0] code);
    int unsigned rate;
    case (code)
      4'h0:    rate = 300;
      4'h1:    rate = 600;
      4'h2:    rate = 1200;
      4'h3:    rate = 2400;
      4'h4:    rate = 4800;
      4'h5:    rate = 9600;
      4'h6:    rate = 19200;
      4'h7:    rate = 38400;
      4'h8:    rate = 57600;
      default: rate = 115200;
    endcase
    return 18'(CLK_HZ / rate);
  endfunction : baud_div

  localparam uart_cfg_t CFG_DEFAULT = '{FRAME_DEFAULT, baud_div(BAUD_9600)};

endpackage : dv_cmd_pkg

// *** logic/decade_value_command_parser.sv ***
// Command front end: bus and serial characters in, decade settings out.
// Assumes bus engine and UART on mclk; switches and thumbwheels are raw pins.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module decade_value_command_parser
  import dv_cmd_pkg::*;
#(
  parameter int unsigned NUM_DECADES = 4,
  parameter int unsigned LSD_POS     = 3,
  parameter bit          HAS_OPEN    = 1'b1,
  parameter bit          HAS_SHORT   = 1'b1
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Panel pins
  input  wire logic [4:0]  addr_switch,
  input  wire logic        local_sel,
  input  wire logic [39:0] thumbwheel,
  // Bus engine
  input  wire char_t       bus_char,
  input  wire logic        bus_gtl,
  output logic [4:0]       listen_addr,
  output logic             listen_en,
  // Serial UART
  input  wire char_t       ser_char,
  output char_t            tx_char,
  input  wire logic        tx_ready,
  output uart_cfg_t        uart_cfg,
  // Register port
  input  wire reg_req_t    reg_req,
  output logic [31:0]      reg_rdata,
  // Decade drivers
  output logic [39:0]      decades,
  output logic             open_circuit_mode,
  output logic             short_circuit_mode,
  output logic             remote_led
);

  localparam int unsigned MODE_POS = LSD_POS + NUM_DECADES;

  function automatic logic [DIGITS-1:0] fit_positions();
    logic [DIGITS-1:0] m;
    m = '0;
    for (int i = 0; i < DIGITS; i++)
      m[i] = (i >= LSD_POS) && (i < MODE_POS);
    return m;
  endfunction : fit_positions

  function automatic logic [39:0] fit_nibbles();
    logic [39:0]       m;
    logic [DIGITS-1:0] p;
    m = '0;
    p = fit_positions();
    for (int i = 0; i < DIGITS; i++)
      m[4*i +: 4] = {4{p[i]}};
    return m;
  endfunction : fit_nibbles

  localparam logic [DIGITS-1:0] FIT_POS = fit_positions();
  localparam logic [39:0]       FIT_MASK = fit_nibbles();

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CASE_BIT) : c;
  endfunction : to_upper

  typedef struct packed {
    logic [4:0]        addr_s1;
    logic [4:0]        addr_s2;
    logic              loc_s1;
    logic              loc_s2;
    logic [39:0]       th_s1;
    logic [39:0]       th_s2;
    logic [1:0]        boot;
    logic [4:0]        listen_addr;
    logic              listen_en;
    logic              remote;
    logic              echo;
    phase_t            phase;
    logic              overflow;
    logic [95:0]       key;
    logic [3:0]        key_len;
    logic [39:0]       val;
    logic [DIGITS-1:0] bad;
    logic [3:0]        val_len;
    logic [39:0]       rem_val;
    out_mode_t         rem_mode;
    logic [39:0]       decades;
    logic              open_m;
    logic              short_m;
    logic              remote_led;
    logic [3:0][7:0]   txq;
    logic [2:0]        txn;
    char_t             tx;
    frame_t            pend;
    uart_cfg_t         cfg;
    logic              err_cmd;
    logic              err_exec;
    logic [31:0]       rdata;
  } state_t;

  state_t s;
  state_t next_s;

  logic        take;
  logic        from_bus;
  logic [7:0]  ch;
  logic        is_value_kw;
  logic        sel_remote;
  frame_t      wr_frame;
  status_t     status;
  logic [1:0]  mode_code;
  logic [2:0]  qi;

  always_comb
  begin
    next_s = s;
    qi = '0;
    mode_code = '0;
    wr_frame = frame_t'(reg_req.wdata[$bits(frame_t)-1:0]);

    // Pin synchronisers
    next_s.addr_s1 = addr_switch;
    next_s.addr_s2 = s.addr_s1;
    next_s.loc_s1 = local_sel;
    next_s.loc_s2 = s.loc_s1;
    next_s.th_s1 = thumbwheel;
    next_s.th_s2 = s.th_s1;

    // Address taken once, after the synchroniser has settled
    if (s.boot != BOOT_DONE)
    begin
      next_s.boot = s.boot + 2'h1;
      if (s.boot == BOOT_LATCH)
      begin
        next_s.listen_addr = s.addr_s2;
        next_s.listen_en = (s.addr_s2 != ADDR_RES_LO) && (s.addr_s2 != ADDR_RES_HI);
      end
    end

    // Transmit queue drains one byte per accepted handshake
    if (s.tx.valid && tx_ready)
      next_s.tx.valid = 1'b0;
    qi = s.txn;
    if (!next_s.tx.valid && s.txn != 3'h0)
    begin
      next_s.tx.valid = 1'b1;
      next_s.tx.data = s.txq[0];
      next_s.txq = {8'h00, s.txq[3:1]};
      qi = s.txn - 3'h1;
    end

    // Bus wins a tie; a serial byte in that cycle is lost
    from_bus = bus_char.valid && s.listen_en;
    take = from_bus || ser_char.valid;
    ch = to_upper(from_bus ? bus_char.data : ser_char.data);

    // Error flags: software clear, hardware set wins below
    if (reg_req.wr && reg_req.addr == REG_STATUS)
    begin
      status = status_t'(reg_req.wdata[$bits(status_t)-1:0]);
      if (status.err_cmd)
        next_s.err_cmd = 1'b0;
      if (status.err_exec)
        next_s.err_exec = 1'b0;
    end

    is_value_kw = (s.key == KW_SHORT) || (s.key == KW_LONG);

    if (take && !from_bus && (ch == CH_ECHO_ON || ch == CH_ECHO_OFF))
      next_s.echo = (ch == CH_ECHO_ON);
    else if (take)
    begin
      if (!from_bus && s.echo && qi < 3'h4)
      begin
        next_s.txq[qi[1:0]] = ch;
        qi = qi + 3'h1;
      end
      if (ch == CH_LF)
      begin
        // Line complete: execute now and nowhere else
        if (s.overflow)
          next_s.err_cmd = 1'b1;
        else if (is_value_kw)
        begin
          if (s.phase != ph_val || s.val_len != 4'(DIGITS) || (s.bad & FIT_POS) != '0)
            next_s.err_exec = 1'b1;
          else
          begin
            next_s.rem_val = s.val & FIT_MASK;
            if (MODE_POS < DIGITS)
              mode_code = s.val[4*MODE_POS +: 2];
            if (mode_code == 2'h1 && HAS_OPEN)
              next_s.rem_mode = mode_open;
            else if (mode_code[1] && HAS_SHORT)
              next_s.rem_mode = mode_short;
            else
              next_s.rem_mode = mode_normal;
            next_s.remote = 1'b1;
          end
        end
        else if (s.key == KW_RESET && s.phase == ph_key)
        begin
          next_s.rem_val = '0;
          next_s.rem_mode = mode_normal;
          next_s.cfg = '{s.pend, baud_div(s.pend.baud_code)};
        end
        else if (!(s.phase == ph_key && s.key_len == 4'h0))
          next_s.err_cmd = 1'b1;
        if (!from_bus)
        begin
          // Prompt ends the message only with echo on; with echo off a line feed follows it
          if (s.echo)
          begin
            next_s.txq[qi[1:0]] = CH_CR;
            next_s.txq[2'(qi + 3'h1)] = CH_LF;
            next_s.txq[2'(qi + 3'h2)] = CH_PROMPT;
            qi = qi + 3'h3;
          end
          else
          begin
            next_s.txq[qi[1:0]] = CH_PROMPT;
            next_s.txq[2'(qi + 3'h1)] = CH_LF;
            qi = qi + 3'h2;
          end
        end
        next_s.phase = ph_key;
        next_s.key = '0;
        next_s.key_len = '0;
        next_s.val = '0;
        next_s.bad = '0;
        next_s.val_len = '0;
        next_s.overflow = 1'b0;
      end
      else if (ch != CH_CR)
      begin
        case (s.phase)
          ph_key:
          begin
            if (ch == CH_SP)
              next_s.phase = ph_val;
            else if (s.key_len == 4'(KW_LEN))
              next_s.overflow = 1'b1;
            else
            begin
              next_s.key = {s.key[87:0], ch};
              next_s.key_len = s.key_len + 4'h1;
            end
          end
          ph_val:
          begin
            if (s.val_len == 4'(DIGITS))
              next_s.overflow = 1'b1;
            else
            begin
              next_s.val = {s.val[35:0], ch[3:0]};
              next_s.bad = {s.bad[DIGITS-2:0], (ch < CH_ZERO) || (ch > CH_NINE)};
              next_s.val_len = s.val_len + 4'h1;
            end
          end
          default:
            next_s.phase = ph_key;
        endcase
      end
    end
    next_s.txn = qi;

    if (bus_gtl)
      next_s.remote = 1'b0;

    // Output selection
    sel_remote = s.remote && !s.loc_s2;
    next_s.decades = sel_remote ? s.rem_val : (s.th_s2 & FIT_MASK);
    next_s.open_m = sel_remote && s.rem_mode == mode_open;
    next_s.short_m = sel_remote && s.rem_mode == mode_short;
    next_s.remote_led = s.remote;

    // Register port
    if (reg_req.wr && reg_req.addr == REG_FRAME && wr_frame.baud_code <= BAUD_MAX)
      next_s.pend = wr_frame;
    status = '{s.short_m, s.open_m, s.err_exec, s.err_cmd, s.listen_addr,
               s.listen_en, s.loc_s2, s.echo, s.remote};
    next_s.rdata = '0;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        REG_FRAME:    next_s.rdata = 32'(s.pend);
        REG_STATUS:   next_s.rdata = 32'(status);
        REG_VALUE_LO: next_s.rdata = s.decades[31:0];
        REG_VALUE_HI: next_s.rdata = 32'(s.decades[39:32]);
        default:      next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.pend <= FRAME_DEFAULT;
      s.cfg <= CFG_DEFAULT;
    end
    else
      s <= next_s;
  end

  assign listen_addr = s.listen_addr;
  assign listen_en = s.listen_en;
  assign tx_char = s.tx;
  assign uart_cfg = s.cfg;
  assign reg_rdata = s.rdata;
  assign decades = s.decades;
  assign open_circuit_mode = s.open_m;
  assign short_circuit_mode = s.short_m;
  assign remote_led = s.remote_led;

endmodule : decade_value_command_parser

// *** sim/dv_cmd_props.sv ***
// Checker for the command parser, watching only its top ports.
// Assumes binding onto every parser instance with its own parameters.
`timescale 1ns/1ps
module dv_cmd_props
  import dv_cmd_pkg::*;
#(
  parameter int unsigned NUM_DECADES = 4,
  parameter int unsigned LSD_POS     = 3
)(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Inputs
  input wire logic [39:0] thumbwheel,
  input wire char_t       bus_char,
  input wire logic        bus_gtl,
  input wire char_t       ser_char,
  input wire logic        tx_ready,
  input wire reg_req_t    reg_req,
  // Outputs
  input wire logic [4:0]  listen_addr,
  input wire logic        listen_en,
  input wire char_t       tx_char,
  input wire uart_cfg_t   uart_cfg,
  input wire logic [31:0] reg_rdata,
  input wire logic [39:0] decades,
  input wire logic        open_circuit_mode,
  input wire logic        short_circuit_mode,
  input wire logic        remote_led
);
  localparam logic [39:0] FIT = ((40'h1 << (4 * NUM_DECADES)) - 40'h1) << (4 * LSD_POS);

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rdata_quiet: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_addr_legal: assert property (listen_en |-> listen_addr inside {[5'h01:5'h1E]})
    else $error("listening at a reserved address");
  a_addr_frozen: assert property ($past(listen_en) |-> listen_en && $stable(listen_addr))
    else $error("bus address moved after power-up");
  a_gtl_drop: assert property (bus_gtl |-> ##2 !remote_led)
    else $error("remote kept after go-to-local");
  a_local_value: assert property ((!remote_led && $stable(thumbwheel))[*5]
    |-> decades == (thumbwheel & FIT)) else $error("local output not thumbwheel");
  a_prompt_due: assert property (ser_char.valid && ser_char.data == CH_LF
    && !bus_char.valid |-> ##2 tx_char.valid) else $error("no answer after line feed");
  a_tx_hold: assert property (tx_char.valid && !tx_ready |=> $stable(tx_char))
    else $error("transmit byte dropped before ready");
  a_tx_gap: assert property (tx_char.valid && tx_ready && tx_char.data == CH_PROMPT
    |=> !tx_char.valid || tx_char.data == CH_LF) else $error("prompt not closed properly");
  a_mode_single: assert property (!(open_circuit_mode && short_circuit_mode))
    else $error("open and short together");
  a_frame_held: assert property (reg_req.wr && reg_req.addr == REG_FRAME
    |=> $stable(uart_cfg)[*3]) else $error("framing applied before reset");

  c_prompt: cover property (tx_char.valid && tx_char.data == CH_PROMPT);
  c_open: cover property ($rose(open_circuit_mode));
  c_gtl: cover property (bus_gtl && remote_led);
endmodule : dv_cmd_props

bind decade_value_command_parser dv_cmd_props #(.NUM_DECADES(NUM_DECADES), .LSD_POS(LSD_POS))
  chk (.mclk(mclk), .sys_rst(sys_rst), .thumbwheel(thumbwheel), .bus_char(bus_char),
  .bus_gtl(bus_gtl), .ser_char(ser_char), .tx_ready(tx_ready), .reg_req(reg_req),
  .listen_addr(listen_addr), .listen_en(listen_en), .tx_char(tx_char), .uart_cfg(uart_cfg),
  .reg_rdata(reg_rdata), .decades(decades), .open_circuit_mode(open_circuit_mode),
  .short_circuit_mode(short_circuit_mode), .remote_led(remote_led));

// *** sim/host_model.sv ***
// Serial host model: sends command lines, collects the answer bytes.
// Assumes the bench calls put and send and reads rx afterwards.
`timescale 1ns/1ps
module host_model
  import dv_cmd_pkg::*;
(
  // Clock and pacing
  input  wire logic  mclk,
  input  wire logic  slow,
  // Byte streams
  output char_t      ser_char,
  input  wire char_t tx_char,
  output logic       tx_ready
);
  logic [7:0] rx[$];
  logic       echo;
  logic [1:0] pace;

  initial
  begin
    ser_char = '0;
    tx_ready = 1'b0;
    echo = 1'b0;
    pace = 2'h0;
  end

  // Slow pacing stalls the transmitter three cycles in four
  always @(posedge mclk)
  begin
    pace <= pace + 2'h1;
    tx_ready <= !slow || pace == 2'h3;
    if (tx_char.valid && tx_ready)
      rx.push_back(tx_char.data);
  end

  // Gap keeps the short transmit queue from overflowing
  task automatic put(input logic [7:0] c);
    @(posedge mclk);
    ser_char <= '{1'b1, c};
    @(posedge mclk);
    ser_char <= '{1'b0, ~c};
    if (c == CH_ECHO_ON || c == CH_ECHO_OFF)
      echo = c == CH_ECHO_ON;
    repeat (10) @(posedge mclk);
  endtask : put

  task automatic send(input string s);
    rx.delete();
    foreach (s[i])
      put(s[i]);
    put(CH_LF);
    for (int k = 0; k < 3000; k++)
    begin
      if (rx.size() > 0 && rx[$] == (echo ? CH_PROMPT : CH_LF))
        break;
      @(posedge mclk);
    end
  endtask : send
endmodule : host_model

// *** sim/test_decade_value_command_parser.sv ***
// Bench for the command parser: serial host model, bus bytes, registers.
// Assumes default parser parameters: four decades from the 1nF place.
`timescale 1ns/1ps
module test_decade_value_command_parser;
  import dv_cmd_pkg::*;
  logic mclk, sys_rst, local_sel, bus_gtl, tx_ready, listen_en, slow;
  logic ocm, scm, remote_led;
  logic [4:0] addr_switch, listen_addr;
  logic [39:0] thumbwheel, decades;
  logic [31:0] reg_rdata, r;
  char_t bus_char, ser_char, tx_char;
  uart_cfg_t uart_cfg;
  reg_req_t reg_req;
  int fails, n_checks, cycles, n;
  string s;

  decade_value_command_parser uut (.mclk(mclk), .sys_rst(sys_rst),
    .addr_switch(addr_switch), .local_sel(local_sel), .thumbwheel(thumbwheel),
    .bus_char(bus_char), .bus_gtl(bus_gtl), .listen_addr(listen_addr),
    .listen_en(listen_en), .ser_char(ser_char), .tx_char(tx_char), .tx_ready(tx_ready),
    .uart_cfg(uart_cfg), .reg_req(reg_req), .reg_rdata(reg_rdata), .decades(decades),
    .open_circuit_mode(ocm), .short_circuit_mode(scm), .remote_led(remote_led));
  host_model host (.mclk(mclk), .slow(slow), .ser_char(ser_char), .tx_char(tx_char),
    .tx_ready(tx_ready));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_n(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : wait_n

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) reg_req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge mclk) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk) reg_req <= '0;
    @(negedge mclk) r = reg_rdata;
  endtask : reg_rd

  task automatic bus_line(input string t);
    for (int i = 0; i <= t.len(); i++)
    begin
      @(posedge mclk) bus_char <= '{1'b1, i < t.len() ? t[i] : CH_LF};
      @(posedge mclk) bus_char <= '{1'b0, ~bus_char.data};
      repeat (4) @(posedge mclk);
    end
    wait_n(4);
  endtask : bus_line

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    {sys_rst, local_sel, bus_gtl, slow} = 4'h8;
    {fails, n_checks, cycles} = '0;
    addr_switch = 5'h1F;
    thumbwheel = 40'h1234567890;
    bus_char = '0;
    reg_req = '0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_n(6);
    check("listen_en", listen_en, 1'b0);
    check("uart_cfg", uart_cfg, {8'h05, 18'd5208});
    check("decades", decades, 40'h0004567000);
    bus_line("SOUR:DATA 0000001000");
    check("remote_led", remote_led, 1'b0);
    @(posedge mclk) addr_switch <= 5'h09;
    wait_n(6);
    check("listen_addr", listen_addr, 5'h1F);
    @(posedge mclk) sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    wait_n(6);
    check("listen_addr", listen_addr, 5'h09);
    $display("test address done");
    host.send("sour:data 0000053200");
    wait_n(3);
    check("prompt", {host.rx[0], host.rx[1]}, {CH_PROMPT, CH_LF});
    check("decades", decades, 40'h0000053000);
    check("remote_led", remote_led, 1'b1);
    @(posedge mclk) local_sel <= 1'b1;
    wait_n(6);
    check("decades", decades, 40'h0004567000);
    @(posedge mclk) local_sel <= 1'b0;
    wait_n(6);
    check("decades", decades, 40'h0000053000);
    $display("test serial value done");
    @(posedge mclk) slow <= 1'b1;
    for (int d = 0; d < 10; d++)
    begin
      s = "SOUR:DATA 0000012300";
      s[12] = 8'(48 + d);
      host.send(s);
      wait_n(3);
      check("open", ocm, d % 4 == 1);
      check("short", scm, d % 4 >= 2);
      check("decades", decades, 40'h0000012000);
    end
    $display("test modes done");
    host.put(CH_ECHO_ON);
    host.send("SOURCE:DATA 0000004000");
    n = host.rx.size();
    check("echo", host.rx[0], "S");
    check("prompt", {host.rx[n - 3], host.rx[n - 2], host.rx[n - 1]}, 24'h0D0A3E);
    check("decades", decades, 40'h0000004000);
    host.put(CH_ECHO_OFF);
    host.send("SOUR:DATA 0000001000");
    check("no echo", host.rx[0], CH_PROMPT);
    $display("test echo done");
    host.send("SOUR:DATA 12345");
    reg_rd(REG_STATUS);
    check("err_exec", r[10], 1'b1);
    check("decades", decades, 40'h0000001000);
    reg_wr(REG_STATUS, 32'h600);
    host.send("BOGUS:CMD 1");
    reg_rd(REG_STATUS);
    check("errors", r[10:9], 2'b01);
    check("decades", decades, 40'h0000001000);
    reg_rd(4'hF);
    check("unmapped", r, 32'h0);
    $display("test errors done");
    @(posedge mclk) bus_gtl <= 1'b1;
    @(posedge mclk) bus_gtl <= 1'b0;
    wait_n(4);
    check("remote_led", remote_led, 1'b0);
    check("decades", decades, 40'h0004567000);
    bus_line("sour:data 0000008000");
    check("remote_led", remote_led, 1'b1);
    check("decades", decades, 40'h0000008000);
    $display("test bus done");
    reg_wr(REG_FRAME, 32'hB9);
    reg_wr(REG_FRAME, 32'h0A);
    reg_rd(REG_FRAME);
    check("frame", r, 32'hB9);
    check("uart_cfg", uart_cfg, {8'h05, 18'd5208});
    host.send("*rst");
    wait_n(3);
    check("uart_cfg", uart_cfg, {8'hB9, 18'd434});
    check("decades", decades, 40'h0);
    $display("test framing done");
    close_out();
  end
endmodule : test_decade_value_command_parser
